// >>> core/smc_top.sv
// serial port mode control: mode register, pin ownership, codec, loopback, wake
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module smc_top (
   // clock, reset, enable
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output      logic [31:0] reg_rdata_o,
   // device power state and port core
   input  wire logic        idle_mode_i,
   input  wire logic        sleep_mode_i,
   input  wire logic        transmit_enable_i,
   input  wire logic        transmit_active_i,
   input  wire logic        rts_request_i,
   input  wire logic        baud_tick16_i,
   input  wire logic        baud_clock_i,
   input  wire logic        tx_serial_i,
   output      logic        rx_serial_o,
   output      logic        cts_o,
   output      logic        run_o,
   output      logic        wake_o,
   output      logic        receive_polarity_invert_o,
   output      logic        high_speed_baud_o,
   output      logic [1:0]  parity_data_select_o,
   output      logic        stop_bit_select_o,
   // pins
   output      logic        transmit_pin_o,
   output      logic        transmit_pin_oe_o,
   input  wire logic        receive_pin_i,
   input  wire logic        clear_to_send_pin_i,
   output      logic        request_to_send_pin_o,
   output      logic        request_to_send_pin_oe_o,
   output      logic        baud_clock_out_pin_o,
   output      logic        baud_clock_out_pin_oe_o
);

   logic [31:0]  serial_port_mode_reg;
   logic [31:0]  serial_port_mode_next;
   logic [15:0]  period_reg;
   logic         rx_s1_reg;
   logic         rx_s2_reg;
   logic         cts_s1_reg;
   logic         cts_s2_reg;
   logic         rx_prev_reg;
   logic [3:0]   ir_tx_phase_reg;
   logic         tx_prev_reg;
   logic [3:0]   ir_rx_cnt_reg;
   logic         on;
   logic         run;
   logic         ir_on;
   logic         loop;
   logic [1:0]   pin_sel;
   logic         tx_line;
   logic         rx_line;
   logic         rx_decoded;
   logic         rts_assert;
   logic         stop_idle;
   logic         hs_pin_mode;
   logic         wake_en;
   logic         auto_baud_req;
   logic [31:0]  status_word;
   logic [31:0]  reg_rdata_next;

   smc_abd_if abd_bus ();

   // mode fields decoded once; the logic below reads these names, except the four fields fed straight to the port core
   assign on            = serial_port_mode_reg[smc_pkg::MODE_ON];
   assign stop_idle     = serial_port_mode_reg[smc_pkg::MODE_STOP_IDLE];
   assign ir_on         = serial_port_mode_reg[smc_pkg::MODE_IR_CODEC];
   assign hs_pin_mode   = serial_port_mode_reg[smc_pkg::MODE_HS_PIN];
   assign pin_sel       = serial_port_mode_reg[smc_pkg::MODE_PIN_SEL_LO +: 2];
   assign wake_en       = serial_port_mode_reg[smc_pkg::MODE_WAKE];
   assign loop          = serial_port_mode_reg[smc_pkg::MODE_LOOP];
   assign auto_baud_req = serial_port_mode_reg[smc_pkg::MODE_AUTO_BAUD];

   // halted while disabled or when idle with stop-in-idle
   assign run = on & ~(stop_idle & idle_mode_i);

   // pin synchronisers; first stages feed only the second
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else if (ce_i) begin
         rx_s1_reg <= receive_pin_i;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cts_s1_reg <= 1'b1;
         cts_s2_reg <= 1'b1;
      end else if (ce_i) begin
         cts_s1_reg <= clear_to_send_pin_i;
         cts_s2_reg <= cts_s1_reg;
      end
   end

   // mode register; a software write in the done cycle wins over the clear
   always_comb begin
      serial_port_mode_next = serial_port_mode_reg;
      if (abd_bus.done) begin
         serial_port_mode_next[smc_pkg::MODE_AUTO_BAUD] = 1'b0;
      end
      if (reg_wr_i && reg_addr_i == smc_pkg::OFS_MODE) begin
         serial_port_mode_next = reg_wdata_i & smc_pkg::MODE_WMASK;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         serial_port_mode_reg <= smc_pkg::MODE_RESET;
      end else if (ce_i) begin
         serial_port_mode_reg <= serial_port_mode_next;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         period_reg <= 16'h0000;
      end else if (ce_i && abd_bus.done) begin
         period_reg <= abd_bus.period;
      end
   end

   // status word: run, pending request, raw handshake level, last period
   always_comb begin
      status_word                                = 32'h0000_0000;
      status_word[smc_pkg::STAT_RUN]             = run;
      status_word[smc_pkg::STAT_ABD_BUSY]        = auto_baud_req;
      status_word[smc_pkg::STAT_CTS]             = cts_s2_reg;
      status_word[smc_pkg::STAT_PERIOD_LO +: 16] = period_reg;
   end

   // read data stand only in the cycle after the strobe; unmapped reads zero
   always_comb begin
      reg_rdata_next = 32'h0000_0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            smc_pkg::OFS_MODE: begin
               reg_rdata_next = serial_port_mode_reg & smc_pkg::MODE_WMASK;
            end
            smc_pkg::OFS_STATUS: begin
               reg_rdata_next = status_word;
            end
            default: begin
               reg_rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         reg_rdata_o <= reg_rdata_next;
      end
   end

   // infrared encoder: a zero bit becomes a short high pulse at bit start
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ir_tx_phase_reg <= 4'h0;
         tx_prev_reg     <= 1'b1;
      end else if (ce_i) begin
         if (!run) begin
            ir_tx_phase_reg <= 4'h0;
            tx_prev_reg     <= 1'b1;
         end else begin
            tx_prev_reg <= tx_serial_i;
            if (tx_serial_i != tx_prev_reg) begin
               ir_tx_phase_reg <= 4'h0;
            end else if (baud_tick16_i) begin
               ir_tx_phase_reg <= ir_tx_phase_reg + 4'h1;
            end
         end
      end
   end

   always_comb begin
      if (ir_on) begin
         tx_line = ~tx_serial_i & (ir_tx_phase_reg < smc_pkg::IR_PULSE_TICKS);
      end else begin
         tx_line = tx_serial_i;
      end
   end

   // loopback takes the line image of transmit data instead of the pin
   assign rx_line = loop ? tx_line : rx_s2_reg;

   // infrared decoder: each high pulse stretches to one low bit time
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ir_rx_cnt_reg <= 4'h0;
      end else if (ce_i) begin
         if (!run) begin
            ir_rx_cnt_reg <= 4'h0;
         end else if (rx_line) begin
            ir_rx_cnt_reg <= smc_pkg::IR_BIT_TICKS;
         end else if (baud_tick16_i && ir_rx_cnt_reg != 4'h0) begin
            ir_rx_cnt_reg <= ir_rx_cnt_reg - 4'h1;
         end
      end
   end

   assign rx_decoded = ir_on ? ~(rx_line | (ir_rx_cnt_reg != 4'h0)) : rx_line;

   // simplex asserts while sending, flow control while receiver has room
   assign rts_assert = hs_pin_mode ? transmit_active_i : rts_request_i;

   // pin ownership; unowned pins are released to port control
   // transmit pin: loopback keeps the external line idle
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         transmit_pin_o    <= 1'b1;
         transmit_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         transmit_pin_o    <= loop ? ~ir_on : tx_line;
         transmit_pin_oe_o <= on & transmit_enable_i;
      end
   end

   // request-to-send pin, active low; owned for pin-enable 01 and 10
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         request_to_send_pin_o    <= 1'b1;
         request_to_send_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         request_to_send_pin_o    <= ~rts_assert;
         request_to_send_pin_oe_o <= on & (pin_sel == smc_pkg::PIN_SEL_RTS ||
                                           pin_sel == smc_pkg::PIN_SEL_CTS_RTS);
      end
   end

   // baud clock pin, owned only for pin-enable 11
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         baud_clock_out_pin_o    <= 1'b0;
         baud_clock_out_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         baud_clock_out_pin_o    <= on & baud_clock_i;
         baud_clock_out_pin_oe_o <= on & (pin_sel == smc_pkg::PIN_SEL_BCLK);
      end
   end

   // clear-to-send read only when that pin is owned, else always clear
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cts_o <= 1'b1;
      end else if (ce_i) begin
         cts_o <= (on && pin_sel == smc_pkg::PIN_SEL_CTS_RTS) ? ~cts_s2_reg : 1'b1;
      end
   end

   // data path and mode fields for the port core
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_serial_o               <= 1'b1;
         run_o                     <= 1'b0;
         receive_polarity_invert_o <= 1'b0;
         high_speed_baud_o         <= 1'b0;
         parity_data_select_o      <= 2'h0;
         stop_bit_select_o         <= 1'b0;
      end else if (ce_i) begin
         rx_serial_o               <= run ? rx_decoded : 1'b1;
         run_o                     <= run;
         receive_polarity_invert_o <= serial_port_mode_reg[smc_pkg::MODE_RX_POL];
         high_speed_baud_o         <= serial_port_mode_reg[smc_pkg::MODE_HS_BAUD];
         parity_data_select_o      <= serial_port_mode_reg[smc_pkg::MODE_PAR_DATA_LO +: 2];
         stop_bit_select_o         <= serial_port_mode_reg[smc_pkg::MODE_STOP_BITS];
      end
   end

   // wake on start-bit falling edge during sleep
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_prev_reg <= 1'b1;
         wake_o      <= 1'b0;
      end else if (ce_i) begin
         rx_prev_reg <= rx_s2_reg;
         wake_o      <= on & sleep_mode_i & wake_en & rx_prev_reg & ~rx_s2_reg;
      end
   end

   // measurement runs only while requested and the port is running
   assign abd_bus.start = run & auto_baud_req;
   assign abd_bus.rx    = rx_decoded;

   smc_autobaud u_autobaud (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .abd       (abd_bus.meas)
   );

endmodule // smc_top
`default_nettype wire

// >>> core/smc_pkg.sv
// constants and types for the serial port mode-control block
package smc_pkg;

   // register map, byte addresses on the plain register port
   localparam int          ADDR_W            = 8;
   localparam logic [7:0]  OFS_MODE          = 8'h00;
   localparam logic [7:0]  OFS_STATUS        = 8'h04;

   // mode register field positions
   localparam int          MODE_ON           = 15;
   localparam int          MODE_STOP_IDLE    = 13;
   localparam int          MODE_IR_CODEC     = 12;
   localparam int          MODE_HS_PIN       = 11;
   localparam int          MODE_PIN_SEL_LO   = 8;
   localparam int          MODE_WAKE         = 7;
   localparam int          MODE_LOOP         = 6;
   localparam int          MODE_AUTO_BAUD    = 5;
   localparam int          MODE_RX_POL       = 4;
   localparam int          MODE_HS_BAUD      = 3;
   localparam int          MODE_PAR_DATA_LO  = 1;
   localparam int          MODE_STOP_BITS    = 0;

   // writable bits; upper half and bits 14, 10 stay zero
   localparam logic [31:0] MODE_WMASK        = 32'h0000_BBFF;
   localparam logic [31:0] MODE_RESET        = 32'h0000_0000;

   // status register field positions
   localparam int          STAT_RUN          = 0;
   localparam int          STAT_ABD_BUSY     = 1;
   localparam int          STAT_CTS          = 2;
   localparam int          STAT_PERIOD_LO    = 16;

   // pin-enable field encodings
   localparam logic [1:0]  PIN_SEL_TX_RX     = 2'h0;
   localparam logic [1:0]  PIN_SEL_RTS       = 2'h1;
   localparam logic [1:0]  PIN_SEL_CTS_RTS   = 2'h2;
   localparam logic [1:0]  PIN_SEL_BCLK      = 2'h3;

   // infrared codec timing, in 16x baud ticks
   localparam logic [3:0]  IR_PULSE_TICKS    = 4'h3;
   localparam logic [3:0]  IR_BIT_TICKS      = 4'hF;

   // auto-baud: sync character gives five falling edges over eight bits
   localparam int          ABD_CNT_W         = 20;
   localparam int          ABD_PERIOD_W      = 16;
   localparam logic [2:0]  ABD_EDGES         = 3'h4;
   localparam int          ABD_BITS_LOG2     = 3;

   typedef enum logic [1:0] {
      ABD_IDLE,
      ABD_WAIT_EDGE,
      ABD_MEASURE
   } smc_abd_state_t;

endpackage

// >>> core/smc_abd_if.sv
// carrier between mode control and the auto-baud measurement unit
`timescale 1ns/1ps
`default_nettype none
interface smc_abd_if;
   logic                                start;
   logic                                rx;
   logic                                done;
   logic [smc_pkg::ABD_PERIOD_W-1:0]    period;

   modport meas (input start, input rx, output done, output period);
   modport ctrl (output start, output rx, input done, input period);
endinterface
`default_nettype wire

// >>> core/smc_autobaud.sv
// auto-baud measurement: times the sync character on the receive line
`timescale 1ns/1ps
`default_nettype none
module smc_autobaud (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   // link to mode control
   smc_abd_if.meas   abd
);

   smc_pkg::smc_abd_state_t                 state_reg;
   logic                                    rx_prev_reg;
   logic [2:0]                              edge_reg;
   logic [smc_pkg::ABD_CNT_W-1:0]           cnt_reg;
   logic                                    fall;

   assign fall = rx_prev_reg & ~abd.rx;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_prev_reg <= 1'b1;
      end else if (ce_i) begin
         rx_prev_reg <= abd.rx;
      end
   end

   // dropping start abandons a measurement at once
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg  <= smc_pkg::ABD_IDLE;
         edge_reg   <= 3'h0;
         cnt_reg    <= '0;
         abd.done   <= 1'b0;
         abd.period <= '0;
      end else if (ce_i) begin
         abd.done <= 1'b0;
         if (!abd.start) begin
            state_reg <= smc_pkg::ABD_IDLE;
         end else begin
            case (state_reg)
               smc_pkg::ABD_IDLE: begin
                  state_reg <= smc_pkg::ABD_WAIT_EDGE;
               end
               smc_pkg::ABD_WAIT_EDGE: begin
                  if (fall) begin
                     edge_reg  <= 3'h0;
                     // the edge cycle itself is the first counted cycle
                     cnt_reg   <= {{(smc_pkg::ABD_CNT_W-1){1'b0}}, 1'b1};
                     state_reg <= smc_pkg::ABD_MEASURE;
                  end
               end
               smc_pkg::ABD_MEASURE: begin
                  cnt_reg <= cnt_reg + 1'b1;
                  if (fall) begin
                     edge_reg <= edge_reg + 3'h1;
                     if (edge_reg + 3'h1 == smc_pkg::ABD_EDGES) begin
                        abd.done   <= 1'b1;
                        abd.period <= cnt_reg[smc_pkg::ABD_BITS_LOG2 +:
                                              smc_pkg::ABD_PERIOD_W];
                        state_reg  <= smc_pkg::ABD_IDLE;
                     end
                  end
               end
               default: begin
                  state_reg <= smc_pkg::ABD_IDLE;
               end
            endcase
         end
      end
   end

endmodule // smc_autobaud
`default_nettype wire

// >>> sim/smc_top_sva.sv
// port-level assertions for the serial port mode-control block
`timescale 1ns/1ps
`default_nettype none
module smc_top_chk (
   // clock and reset
   input wire logic        sys_clk_i,
   input wire logic        sys_rst_i,
   // register port and device state
   input wire logic [7:0]  reg_addr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic        idle_mode_i,
   input wire logic        sleep_mode_i,
   input wire logic        transmit_enable_i,
   input wire logic        baud_clock_i,
   input wire logic        receive_pin_i,
   // observed outputs
   input wire logic        run_o,
   input wire logic        wake_o,
   input wire logic        cts_o,
   input wire logic        transmit_pin_oe_o,
   input wire logic        request_to_send_pin_oe_o,
   input wire logic        baud_clock_out_pin_o,
   input wire logic        baud_clock_out_pin_oe_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // idle low makes run_o a one-cycle-late copy of the enable bit
   property p_mode_rsvd;
      $past(reg_rd_i && reg_addr_i == smc_pkg::OFS_MODE) |-> (reg_rdata_o & ~smc_pkg::MODE_WMASK) == 0;
   endproperty
   a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode bits set");
   property p_off_no_pins;
      $past(!idle_mode_i) && !run_o |-> !(transmit_pin_oe_o || request_to_send_pin_oe_o || baud_clock_out_pin_oe_o);
   endproperty
   a_off_no_pins: assert property (p_off_no_pins) else $error("pin driven while off");
   property p_tx_oe;
      $past(!idle_mode_i) |-> transmit_pin_oe_o == (run_o && $past(transmit_enable_i));
   endproperty
   a_tx_oe: assert property (p_tx_oe) else $error("transmit enable mismatch");
   property p_bclk;
      $past(!idle_mode_i) |-> baud_clock_out_pin_o == (run_o && $past(baud_clock_i));
   endproperty
   a_bclk: assert property (p_bclk) else $error("baud clock pin mismatch");
   property p_pin_excl;
      !(baud_clock_out_pin_oe_o && request_to_send_pin_oe_o);
   endproperty
   a_pin_excl: assert property (p_pin_excl) else $error("baud clock and rts both owned");
   property p_cts_off;
      $past(!idle_mode_i) && !run_o |-> cts_o;
   endproperty
   a_cts_off: assert property (p_cts_off) else $error("clear-to-send low while off");
   property p_wake_pulse;
      wake_o |=> !wake_o;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
   property p_wake_cause;
      wake_o |-> $past(sleep_mode_i) && !$past(receive_pin_i, 3);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
   c_wake: cover property (wake_o);
   c_bclk: cover property (baud_clock_out_pin_oe_o && baud_clock_out_pin_o);
   c_read: cover property (reg_rdata_o != 32'h0000_0000);
endmodule  // smc_top_chk
bind smc_top smc_top_chk u_chk (
   .sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .idle_mode_i,
   .sleep_mode_i, .transmit_enable_i, .baud_clock_i, .receive_pin_i, .run_o,
   .wake_o, .cts_o, .transmit_pin_oe_o, .request_to_send_pin_oe_o,
   .baud_clock_out_pin_o, .baud_clock_out_pin_oe_o
);
`default_nettype wire

// >>> sim/smc_line_model.sv
// far-end serial device on the receive and clear-to-send lines
`timescale 1ns/1ps
`default_nettype none
module smc_line_model (
   // clock and line
   input  wire logic sys_clk_i,
   output var logic  rx_line_o,
   output var logic  cts_n_o
);
   // line idles high; peer starts not ready
   initial begin
      rx_line_o = 1'b1;
      cts_n_o   = 1'b1;
   end
   // start bit, eight data bits lsb first, stop bit
   task automatic send_byte(input logic [7:0] b, input int bit_cycles);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk_i) rx_line_o <= f[i];
         repeat (bit_cycles - 1) @(posedge sys_clk_i);
      end
   endtask
   // peer flow control; the pin is active low
   task automatic set_ready(input logic ready);
      @(posedge sys_clk_i) cts_n_o <= ~ready;
   endtask
endmodule  // smc_line_model
`default_nettype wire

// >>> sim/testbench.sv
// testbench for the serial port mode-control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        idle = 1'b0, slp = 1'b0, te = 1'b1, ta = 1'b0, rtsr = 1'b0;
   logic        tick = 1'b0, bclk = 1'b0, txs = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [1:0]  pds;
   logic        rxs, cts, run, wake, rinv, hsb, stb, txp, txoe, rtsp, rtsoe, bcp, bcoe, rxl, ctsn;
   int          fail_count = 0, total_checks = 0, cyc = 0, wake_cnt = 0;
   smc_top dut (
      .sys_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .idle_mode_i(idle),
      .sleep_mode_i(slp), .transmit_enable_i(te), .transmit_active_i(ta),
      .rts_request_i(rtsr), .baud_tick16_i(tick), .baud_clock_i(bclk), .tx_serial_i(txs),
      .rx_serial_o(rxs), .cts_o(cts), .run_o(run), .wake_o(wake),
      .receive_polarity_invert_o(rinv), .high_speed_baud_o(hsb), .parity_data_select_o(pds),
      .stop_bit_select_o(stb), .transmit_pin_o(txp), .transmit_pin_oe_o(txoe),
      .receive_pin_i(rxl), .clear_to_send_pin_i(ctsn), .request_to_send_pin_o(rtsp),
      .request_to_send_pin_oe_o(rtsoe), .baud_clock_out_pin_o(bcp),
      .baud_clock_out_pin_oe_o(bcoe)
   );
   smc_line_model line (.sys_clk_i(clk), .rx_line_o(rxl), .cts_n_o(ctsn));
   always #2.5 clk = ~clk;
   // baud tick every fourth cycle keeps codec timing short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= (cyc[1:0] == 2'h3);
      bclk <= cyc[2];
      if (wake === 1'b1)
         wake_cnt <= wake_cnt + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // pin outputs trail the mode register and the synchronisers
   task automatic st();
      repeat (4) @(posedge clk);
      #1;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 chk({txp, txoe, rtsp, rtsoe, bcp, bcoe, cts, rxs, run, wake}, 10'h28C);
      @(posedge clk) rst <= 1'b0;
      rchk(smc_pkg::OFS_MODE, 32'h0000_0000);
      wreg(smc_pkg::OFS_MODE, 32'hFFFF_7FFF);
      wreg(smc_pkg::OFS_STATUS, 32'hFFFF_FFFF);
      wreg(8'h08, 32'hFFFF_FFFF);
      rchk(smc_pkg::OFS_MODE, 32'h0000_3BFF);
      rchk(8'h08, 32'h0000_0000);
      chk({rinv, hsb, pds, stb, txoe, rtsoe, bcoe, run}, 9'h1F0);
      for (int k = 0; k < 4; k++) begin
         wreg(smc_pkg::OFS_MODE, 32'h0000_8000 | 32'(k << 8));
         st();
         chk({txoe, rtsoe, bcoe}, {1'b1, k == 1 || k == 2, k == 3});
         chk(cts, k != 2);
      end
      wreg(smc_pkg::OFS_MODE, 32'h0000_8200);
      line.set_ready(1'b1);
      st();
      chk(cts, 1'b1);
      line.set_ready(1'b0);
      @(posedge clk) te <= 1'b0;
      st();
      chk(txoe, 1'b0);
      @(posedge clk) rtsr <= 1'b1;
      wreg(smc_pkg::OFS_MODE, 32'h0000_8900);
      st();
      chk(rtsp, 1'b1);
      @(posedge clk) ta <= 1'b1;
      st();
      chk(rtsp, 1'b0);
      wreg(smc_pkg::OFS_MODE, 32'h0000_8100);
      st();
      chk(rtsp, 1'b0);
      @(posedge clk) rtsr <= 1'b0;
      st();
      chk(rtsp, 1'b1);
      wreg(smc_pkg::OFS_MODE, 32'h0000_A000);
      @(posedge clk) idle <= 1'b1;
      st();
      chk(run, 1'b0);
      wreg(smc_pkg::OFS_MODE, 32'h0000_8040);
      st();
      chk(run, 1'b1);
      @(posedge clk) idle <= 1'b0;
      @(posedge clk) txs <= 1'b0;
      st();
      chk({rxs, txp}, 2'h1);
      @(posedge clk) txs <= 1'b1;
      wreg(smc_pkg::OFS_MODE, 32'h0000_9000);
      st();
      chk({txp, rxs}, 2'h0);
      @(posedge clk) txs <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk(txp, 1'b1);
      repeat (24) @(posedge clk);
      #1 chk(txp, 1'b0);
      @(posedge clk) txs <= 1'b1;
      wreg(smc_pkg::OFS_MODE, 32'h0000_8080);
      @(posedge clk) slp <= 1'b1;
      line.send_byte(8'hFF, 4);
      st();
      chk(wake_cnt, 1);
      wreg(smc_pkg::OFS_MODE, 32'h0000_8000);
      line.send_byte(8'hFF, 4);
      st();
      chk(wake_cnt, 1);
      @(posedge clk) slp <= 1'b0;
      wreg(smc_pkg::OFS_MODE, 32'h0000_8020);
      rchk(smc_pkg::OFS_STATUS, 32'h0000_0007);
      line.send_byte(8'h55, 16);
      st();
      rchk(smc_pkg::OFS_MODE, 32'h0000_8000);
      rchk(smc_pkg::OFS_STATUS, 32'h0010_0005);
      wreg(smc_pkg::OFS_MODE, 32'h0000_0000);
      @(posedge clk);
      rchk(smc_pkg::OFS_STATUS, 32'h0010_0004);
      wrap_up();
   end
endmodule  // testbench
`default_nettype wire
